// ==== link_credit_map.svh ====
// register offsets, field positions, reset values and widths of the link credit capability bank
// assumes inclusion by bare name from packages and modules that need the map
`ifndef LINK_CREDIT_MAP_SVH
`define LINK_CREDIT_MAP_SVH

// ------------------------------------------------------------
// byte offsets on the register bus
// ------------------------------------------------------------
`define OFF_CREDIT_CONTROL 12'h000
`define OFF_AGENT_STATUS 12'h004
`define OFF_LINK_SEND_CAPABILITY 12'h008
`define OFF_LINK_RECEIVE_CAPABILITY 12'h00C

// ------------------------------------------------------------
// field layout
// ------------------------------------------------------------
`define CREDIT_FIELD_W 10
`define MEMORY_FIELD_LSB 0
`define SNOOP_FIELD_LSB 10
`define DATA_FIELD_LSB 20
`define CREDIT_FIELD_MAX 10'h3FF
`define SCOPE_BIT_POS 0
`define LINK_COUNT_LSB 8
`define LINK_COUNT_W 6
`define REQUEST_AGENT_POS 0
`define HOME_AGENT_POS 1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RESET_SCOPE 1'b0
`define RESET_LINK_COUNT 6'h01
`define RESET_WORD 32'h0000_0000

`endif

// ==== link_credit_pkg.sv ====
// types shared by the link credit capability bank
// assumes the map header is reachable by bare name
`include "link_credit_map.svh"

package link_credit_pkg;

  typedef logic [`CREDIT_FIELD_W-1:0] credit_count_t;
  typedef logic [`LINK_COUNT_W-1:0] link_count_t;

  // whole state of the bank top
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic credit_scope_bit;
    link_count_t link_count;
    logic [31:0] link_send_capability;
    logic [31:0] link_receive_capability;
  } bank_state_s;

endpackage

// ==== level_sync.sv ====
// two flip-flop synchroniser for a group of slow levels
// assumes inputs are quasi-static pins from outside the pclk domain
`timescale 1ns/10ps

module level_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [WIDTH-1:0] async_level,
  output logic [WIDTH-1:0] sync_level
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_s;

  sync_state_s state_ff;
  sync_state_s nxt_state;

  // meta stage feeds only the stable stage
  always_comb begin
    nxt_state.meta = async_level;
    nxt_state.stable = state_ff.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_level = state_ff.stable;

endmodule

// ==== credit_limit_encoder.sv ====
// one 10-bit credit field: per-link value or shared total, saturated, gated by agent presence
// assumes its inputs are already on pclk; purely combinational
`timescale 1ns/10ps
`include "link_credit_map.svh"

module credit_limit_encoder
  import link_credit_pkg::*;
(
  // configuration
  input wire logic [`CREDIT_FIELD_W-1:0] per_link_limit,
  input wire logic [`LINK_COUNT_W-1:0] link_count,
  input wire logic shared_scope,
  input wire logic agent_ok,
  // encoded field
  output logic [`CREDIT_FIELD_W-1:0] field_value
);

  logic [15:0] product;

  // shared pool is the sum of per-link resources, capped at the field's reach
  always_comb begin
    product = 16'(per_link_limit) * 16'(link_count);
    if (!agent_ok) begin
      field_value = '0;
    end else if (!shared_scope) begin
      field_value = per_link_limit;
    end else if (product > 16'(`CREDIT_FIELD_MAX)) begin
      field_value = `CREDIT_FIELD_MAX;
    end else begin
      field_value = product[`CREDIT_FIELD_W-1:0];
    end
  end

endmodule

// ==== link_credit_capability_regs.sv ====
// link credit capability bank: send and receive capability words behind an APB slave
// assumes an APB master on pclk, and agent-presence straps that are static pins
`timescale 1ns/10ps
`include "link_credit_map.svh"

// Summary of operation
// - no request or home agents means memory request send field reads zero.
// - send word bits 19:10 hold outstanding snoop send credits.
// - send word bits 29:20 hold data packet send credits, plain 0 to 1023.
// - scope bit 0 gives per-link counts; 1 gives one total over all links.
// - receive word bits 9:0 hold memory request receive credits.
// - receive word bits 19:10 hold snoop receive credits, plain 0 to 1023.
// - no request agent means snoop receive field reads zero.
// - receive word bits 29:20 hold data packet receive credits.
// - data receive field is a plain binary count from 0 to 1023.
module link_credit_capability_regs
  import link_credit_pkg::*;
#(
  parameter int ADDR_W = 12,
  // per-link send limits
  parameter logic [`CREDIT_FIELD_W-1:0] MEMORY_SEND_PER_LINK = 10'h040,
  parameter logic [`CREDIT_FIELD_W-1:0] SNOOP_SEND_PER_LINK = 10'h020,
  parameter logic [`CREDIT_FIELD_W-1:0] DATA_SEND_PER_LINK = 10'h040,
  // per-link receive limits
  parameter logic [`CREDIT_FIELD_W-1:0] MEMORY_RECEIVE_PER_LINK = 10'h040,
  parameter logic [`CREDIT_FIELD_W-1:0] SNOOP_RECEIVE_PER_LINK = 10'h020,
  parameter logic [`CREDIT_FIELD_W-1:0] DATA_RECEIVE_PER_LINK = 10'h040
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // agent presence straps, asynchronous
  input wire logic request_agent_present,
  input wire logic home_agent_present,
  // capability words and scope toward the port logic
  output logic credit_scope_bit,
  output logic [`LINK_COUNT_W-1:0] link_count,
  output logic [31:0] link_send_capability,
  output logic [31:0] link_receive_capability
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  bank_state_s state_ff;
  bank_state_s nxt_state;

  localparam bank_state_s RESET_STATE = '{
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: `RESET_WORD,
    credit_scope_bit: `RESET_SCOPE,
    link_count: `RESET_LINK_COUNT,
    link_send_capability: `RESET_WORD,
    link_receive_capability: `RESET_WORD
  };

  // ------------------------------------------------------------
  // agent presence
  // ------------------------------------------------------------
  logic [1:0] agent_raw;
  logic [1:0] agent_sync;
  logic request_agent;
  logic home_agent;
  logic any_requester;

  assign agent_raw = {home_agent_present, request_agent_present};

  level_sync #(
    .WIDTH(2)
  ) u_agent_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_level(agent_raw),
    .sync_level(agent_sync)
  );

  assign request_agent = agent_sync[`REQUEST_AGENT_POS];
  assign home_agent = agent_sync[`HOME_AGENT_POS];
  assign any_requester = request_agent | home_agent;

  // ------------------------------------------------------------
  // credit fields
  // ------------------------------------------------------------
  logic [`CREDIT_FIELD_W-1:0] memory_request_send_limit;
  logic [`CREDIT_FIELD_W-1:0] snoop_send_limit;
  logic [`CREDIT_FIELD_W-1:0] data_packet_send_limit;
  logic [`CREDIT_FIELD_W-1:0] memory_request_receive_limit;
  logic [`CREDIT_FIELD_W-1:0] snoop_receive_limit;
  logic [`CREDIT_FIELD_W-1:0] data_packet_receive_limit;

  // memory requests need a requester of either kind
  credit_limit_encoder u_mem_send (
    .per_link_limit(MEMORY_SEND_PER_LINK),
    .link_count(state_ff.link_count),
    .shared_scope(state_ff.credit_scope_bit),
    .agent_ok(any_requester),
    .field_value(memory_request_send_limit)
  );

  // snoops and data are sent whatever agents exist
  credit_limit_encoder u_snp_send (
    .per_link_limit(SNOOP_SEND_PER_LINK),
    .link_count(state_ff.link_count),
    .shared_scope(state_ff.credit_scope_bit),
    .agent_ok(1'b1),
    .field_value(snoop_send_limit)
  );

  credit_limit_encoder u_dat_send (
    .per_link_limit(DATA_SEND_PER_LINK),
    .link_count(state_ff.link_count),
    .shared_scope(state_ff.credit_scope_bit),
    .agent_ok(1'b1),
    .field_value(data_packet_send_limit)
  );

  // receive counts also bound what may be granted to all destinations
  credit_limit_encoder u_mem_rcv (
    .per_link_limit(MEMORY_RECEIVE_PER_LINK),
    .link_count(state_ff.link_count),
    .shared_scope(state_ff.credit_scope_bit),
    .agent_ok(1'b1),
    .field_value(memory_request_receive_limit)
  );

  // only a request agent can take snoops
  credit_limit_encoder u_snp_rcv (
    .per_link_limit(SNOOP_RECEIVE_PER_LINK),
    .link_count(state_ff.link_count),
    .shared_scope(state_ff.credit_scope_bit),
    .agent_ok(request_agent),
    .field_value(snoop_receive_limit)
  );

  // data packets may be taken by any port
  credit_limit_encoder u_dat_rcv (
    .per_link_limit(DATA_RECEIVE_PER_LINK),
    .link_count(state_ff.link_count),
    .shared_scope(state_ff.credit_scope_bit),
    .agent_ok(1'b1),
    .field_value(data_packet_receive_limit)
  );

  // ------------------------------------------------------------
  // word assembly
  // ------------------------------------------------------------
  logic [31:0] send_word;
  logic [31:0] receive_word;

  always_comb begin
    send_word = `RESET_WORD;
    send_word[`MEMORY_FIELD_LSB +: `CREDIT_FIELD_W] = memory_request_send_limit;
    send_word[`SNOOP_FIELD_LSB +: `CREDIT_FIELD_W] = snoop_send_limit;
    send_word[`DATA_FIELD_LSB +: `CREDIT_FIELD_W] = data_packet_send_limit;
    send_word[31:30] = 2'b00;
  end

  always_comb begin
    receive_word = `RESET_WORD;
    receive_word[`MEMORY_FIELD_LSB +: `CREDIT_FIELD_W] = memory_request_receive_limit;
    receive_word[`SNOOP_FIELD_LSB +: `CREDIT_FIELD_W] = snoop_receive_limit;
    receive_word[`DATA_FIELD_LSB +: `CREDIT_FIELD_W] = data_packet_receive_limit;
    receive_word[31:30] = 2'b00;
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic setup_phase;
  logic access_done;
  logic aligned;
  logic hit_control;
  logic hit_status;
  logic hit_send;
  logic hit_receive;
  logic mapped;
  logic [11:0] word_addr;

  assign setup_phase = psel & ~penable;
  // a transfer ends at the edge where pready is seen high in the access phase
  assign access_done = psel & penable & state_ff.pready;
  assign word_addr = 12'(paddr);
  assign aligned = (paddr[1:0] == 2'h0);
  // one aligned word per offset; anything else selects nothing and is refused
  always_comb begin
    hit_control = 1'b0;
    hit_status = 1'b0;
    hit_send = 1'b0;
    hit_receive = 1'b0;
    if (aligned) begin
      unique case (word_addr)
        `OFF_CREDIT_CONTROL: begin
          hit_control = 1'b1;
        end
        `OFF_AGENT_STATUS: begin
          hit_status = 1'b1;
        end
        `OFF_LINK_SEND_CAPABILITY: begin
          hit_send = 1'b1;
        end
        `OFF_LINK_RECEIVE_CAPABILITY: begin
          hit_receive = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end
  assign mapped = hit_control | hit_status | hit_send | hit_receive;

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] control_word;
  logic [31:0] status_word;
  logic [31:0] read_word;

  always_comb begin
    control_word = `RESET_WORD;
    control_word[`SCOPE_BIT_POS] = state_ff.credit_scope_bit;
    control_word[`LINK_COUNT_LSB +: `LINK_COUNT_W] = state_ff.link_count;
  end

  always_comb begin
    status_word = `RESET_WORD;
    status_word[`REQUEST_AGENT_POS] = request_agent;
    status_word[`HOME_AGENT_POS] = home_agent;
  end

  // read from the registered words so a read sees one coherent snapshot
  always_comb begin
    read_word = `RESET_WORD;
    unique case (1'b1)
      hit_control: begin
        read_word = control_word;
      end
      hit_status: begin
        read_word = status_word;
      end
      hit_send: begin
        read_word = state_ff.link_send_capability;
      end
      hit_receive: begin
        read_word = state_ff.link_receive_capability;
      end
      default: begin
        read_word = `RESET_WORD;
      end
    endcase
  end

  // ------------------------------------------------------------
  // response
  // ------------------------------------------------------------
  logic answer_error;
  logic [31:0] answer_data;

  // writes answer with zero data; refused addresses raise the error and return zero
  always_comb begin
    answer_error = ~mapped;
    answer_data = `RESET_WORD;
    if (!pwrite && mapped) begin
      answer_data = read_word;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic write_control;

  // writes to the capability words fall through here and change nothing
  assign write_control = access_done & pwrite & hit_control;

  // ------------------------------------------------------------
  // control write lanes
  // ------------------------------------------------------------
  logic scope_write;
  logic count_write;
  logic written_scope;
  logic [`LINK_COUNT_W-1:0] written_link_count;

  // lane 0 carries the scope bit, lane 1 the link count; other lanes are ignored
  assign scope_write = write_control & pstrb[0];
  assign count_write = write_control & pstrb[1];
  assign written_scope = pwdata[`SCOPE_BIT_POS];
  assign written_link_count = pwdata[`LINK_COUNT_LSB +: `LINK_COUNT_W];

  always_comb begin
    nxt_state = state_ff;
    // capability words track their sources every cycle
    nxt_state.link_send_capability = send_word;
    nxt_state.link_receive_capability = receive_word;
    if (setup_phase) begin
      // one wait-free access phase: answer is ready for the edge that ends it
      nxt_state.pready = 1'b1;
      nxt_state.pslverr = answer_error;
      nxt_state.prdata = answer_data;
    end else if (access_done) begin
      nxt_state.pready = 1'b0;
      nxt_state.pslverr = 1'b0;
      nxt_state.prdata = `RESET_WORD;
    end
    if (scope_write) begin
      nxt_state.credit_scope_bit = written_scope;
    end
    if (count_write) begin
      nxt_state.link_count = written_link_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RESET_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output is a flop of the state struct
  assign pready = state_ff.pready;
  assign prdata = state_ff.prdata;
  assign pslverr = state_ff.pslverr;
  assign credit_scope_bit = state_ff.credit_scope_bit;
  assign link_count = state_ff.link_count;
  assign link_send_capability = state_ff.link_send_capability;
  assign link_receive_capability = state_ff.link_receive_capability;

endmodule

// ==== link_credit_capability_regs_assertions.sv ====
// checker for the link credit capability bank
// assumes bind to the bank top; straps held steady around writes
`timescale 1ns/10ps
`include "link_credit_map.svh"

module link_credit_capability_regs_checker #(
  parameter int ADDR_W = 12,
  parameter logic [`CREDIT_FIELD_W-1:0] DATA_SEND_PER_LINK = 10'h040,
  parameter logic [`CREDIT_FIELD_W-1:0] DATA_RECEIVE_PER_LINK = 10'h040
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // straps and words
  input wire logic request_agent_present,
  input wire logic home_agent_present,
  input wire logic credit_scope_bit,
  input wire logic [`LINK_COUNT_W-1:0] link_count,
  input wire logic [31:0] link_send_capability,
  input wire logic [31:0] link_receive_capability
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // expected data fields, saturating total
  // ----
  logic [15:0] ps, pr;
  logic [9:0] es, er;
  assign ps = {6'h00, DATA_SEND_PER_LINK} * {10'h000, link_count};
  assign pr = {6'h00, DATA_RECEIVE_PER_LINK} * {10'h000, link_count};
  assign es = !credit_scope_bit ? DATA_SEND_PER_LINK : (ps > 16'h03FF ? 10'h3FF : ps[9:0]);
  assign er = !credit_scope_bit ? DATA_RECEIVE_PER_LINK : (pr > 16'h03FF ? 10'h3FF : pr[9:0]);
  // ----
  // sequences
  // ----
  sequence setup_s;
    psel && !penable;
  endsequence
  // three steady edges also cover the word load just after reset
  sequence cfg_steady_s;
    ($stable(credit_scope_bit) && $stable(link_count))[*3];
  endsequence
  // two sync flops plus the word register
  sequence no_agents_s;
    (!request_agent_present && !home_agent_present)[*4];
  endsequence
  // ----
  // assertions
  // ----
  ready_pulse_a: assert property (setup_s |=> pready ##1 !pready) else $error("pready not one cycle");
  idle_quiet_a: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("idle bus not zero");
  bad_addr_a: assert property (setup_s ##0 (paddr > 12'h00C || paddr[1:0] != 2'b00) |=>
    pslverr && prdata == 32'h0) else $error("bad address not refused");
  send_read_a: assert property (setup_s ##0 (!pwrite && paddr == 12'h008) |=>
    prdata == $past(link_send_capability)) else $error("send word read wrong");
  recv_read_a: assert property (setup_s ##0 (!pwrite && paddr == 12'h00C) |=>
    prdata == $past(link_receive_capability)) else $error("receive word read wrong");
  top_bits_a: assert property (link_send_capability[31:30] == 2'b00 &&
    link_receive_capability[31:30] == 2'b00) else $error("top bits not zero");
  mem_gate_a: assert property (no_agents_s |-> link_send_capability[9:0] == 10'h000)
    else $error("memory send not zero");
  snoop_gate_a: assert property ((!request_agent_present)[*4] |-> link_receive_capability[19:10] == 10'h000)
    else $error("snoop receive not zero");
  data_send_a: assert property (cfg_steady_s |-> link_send_capability[29:20] == es)
    else $error("data send field wrong");
  data_recv_a: assert property (cfg_steady_s |-> link_receive_capability[29:20] == er)
    else $error("data receive field wrong");
endmodule

bind link_credit_capability_regs link_credit_capability_regs_checker #(.ADDR_W(ADDR_W),
  .DATA_SEND_PER_LINK(DATA_SEND_PER_LINK), .DATA_RECEIVE_PER_LINK(DATA_RECEIVE_PER_LINK)) checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .request_agent_present(request_agent_present),
  .home_agent_present(home_agent_present), .credit_scope_bit(credit_scope_bit), .link_count(link_count),
  .link_send_capability(link_send_capability), .link_receive_capability(link_receive_capability));

// ==== link_credit_capability_regs_test.sv ====
// self-checking bench for the link credit capability bank
// assumes the bank answers each apb access in one cycle
`timescale 1ns/10ps
`include "link_credit_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end

module link_credit_capability_regs_test;
  import link_credit_pkg::*;
  // odd per-link limits so fields cannot alias
  localparam logic [9:0] MS = 10'h155, SS = 10'h011, DS = 10'h3FF, MR = 10'h001, SR = 10'h2AA, DR = 10'h0C3;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic request_agent_present = 1, home_agent_present = 1, scope = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, link_send_capability, link_receive_capability;
  logic pready, pslverr, credit_scope_bit;
  logic [3:0] pstrb = 4'hF;
  logic [5:0] link_count, lc = 6'h01;
  logic [5:0] lcs[7] = '{6'h01, 6'h02, 6'h3C, 6'h3D, 6'h3F, 6'h00, 6'h00};
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int n_fail = 0, checked = 0, cycles = 0;

  link_credit_capability_regs #(.MEMORY_SEND_PER_LINK(MS), .SNOOP_SEND_PER_LINK(SS), .DATA_SEND_PER_LINK(DS),
    .MEMORY_RECEIVE_PER_LINK(MR), .SNOOP_RECEIVE_PER_LINK(SR), .DATA_RECEIVE_PER_LINK(DR))
    link_credit_capability_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .request_agent_present(request_agent_present), .home_agent_present(home_agent_present),
    .credit_scope_bit(credit_scope_bit), .link_count(link_count),
    .link_send_capability(link_send_capability), .link_receive_capability(link_receive_capability));

  initial begin
    forever #20 pclk = ~pclk;
  end

  // ----
  // expectations
  // ----
  function automatic logic [9:0] f(logic [9:0] per, logic ok);
    logic [15:0] p;
    p = {6'h00, per} * {10'h000, lc};
    if (!ok) return 10'h000;
    if (!scope) return per;
    return (p > 16'h03FF) ? 10'h3FF : p[9:0];
  endfunction
  function automatic logic [31:0] sw();
    return {2'b00, f(DS, 1'b1), f(SS, 1'b1), f(MS, request_agent_present | home_agent_present)};
  endfunction
  function automatic logic [31:0] rw();
    return {2'b00, f(DR, 1'b1), f(SR, request_agent_present), f(MR, 1'b1)};
  endfunction

  // ----
  // apb master, notes expected answer first
  // ----
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    exp_q.push_back(x);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic check_words();
    `CHK(link_send_capability, sw())
    `CHK(link_receive_capability, rw())
    apb(1'b0, 12'h008, 32'h0, {1'b0, sw()});
    apb(1'b0, 12'h00C, 32'h0, {1'b0, rw()});
  endtask
  // control word takes one more edge to reach the capability words
  task automatic ctrl(input logic s, input logic [5:0] l);
    scope = s;
    lc = l;
    apb(1'b1, 12'h000, {18'h0, l, 7'h00, s}, 33'h0);
    repeat (2) @(posedge pclk);
    `CHK({credit_scope_bit, link_count}, {s, l})
  endtask
  task automatic close_out();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----
  // monitor
  // ----
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      close_out();
    end
    if (pready === 1'b1) begin
      `CHK(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0) begin
        e = exp_q.pop_front();
        `CHK({pslverr, prdata}, e)
      end
    end
  end

  // ----
  // scenarios
  // ----
  initial begin
    void'($urandom(32'hEA2D5AEE));
    lcs[6] = 6'($urandom_range(63, 1));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK({credit_scope_bit, link_count}, 7'h01)
    for (int i = 0; i < 4; i++) begin
      request_agent_present <= i[0];
      home_agent_present <= i[1];
      repeat (5) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0, {31'h0, i[1:0]});
      check_words();
    end
    foreach (lcs[i]) begin
      ctrl(1'b1, lcs[i]);
      check_words();
    end
    ctrl(1'b0, 6'($urandom));
    // lane 1 off: the scope bit lands, the link count must not move
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'h0000_3F01, 33'h0);
    pstrb <= 4'hF;
    scope = 1'b1;
    repeat (2) @(posedge pclk);
    `CHK({credit_scope_bit, link_count}, {1'b1, lc})
    apb(1'b1, 12'h008, $urandom, 33'h0);
    apb(1'b1, 12'h00C, $urandom, 33'h0);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h001, 32'hFFFF_FFFF, {1'b1, 32'h0});
    repeat (2) @(posedge pclk);
    `CHK({credit_scope_bit, link_count}, {scope, lc})
    check_words();
    close_out();
  end
endmodule
